/* File: ccsd_mem.sv */
// shared constants, decode types and the small dual-port byte-lane memory
`timescale 1ns/1ps
package ccsd_pkg;
   // card bus widths
   localparam int          ADDR_W      = 11;
   localparam int          DATA_W      = 16;
   localparam int          SYNC_STAGES = 2;
   localparam int          CM_AW       = 10;    // common memory word address
   localparam int          INFO_AW     = 8;     // card info area byte address
   // configuration register indices, taken from address bits 2..1
   localparam logic [1:0]  CFG_IDX_MODE = 2'h0;
   localparam logic [1:0]  CFG_IDX_COND = 2'h1;
   localparam logic [1:0]  CFG_IDX_PIN  = 2'h2;
   localparam logic [1:0]  CFG_IDX_SOCK = 2'h3;
   // values after reset
   localparam logic [7:0]  MODE_RST = 8'h00;
   localparam logic [7:0]  COND_RST = 8'h00;
   localparam logic [7:0]  PIN_RST  = 8'h00;
   localparam logic [7:0]  SOCK_RST = 8'h00;
   // field positions
   localparam int          MODE_SRESET  = 7;
   localparam int          MODE_LEVIREQ = 6;
   localparam int          COND_CHANGED = 7;
   localparam int          COND_INT     = 1;
   localparam int          COND_PWRDWN  = 2;
   localparam logic [7:0]  COND_WR_MASK = 8'h64;   // sigchg, iois8, pwrdwn
   localparam int          PIN_CRDY     = 5;
   localparam int          PIN_CWPROT   = 4;
   localparam int          PIN_MRDY     = 1;
   localparam int          PIN_MWPROT   = 0;

   typedef enum logic [2:0] {SP_NONE, SP_COMMON, SP_INFO, SP_CFG, SP_INVALID} ccsd_space_t;

   typedef struct packed {
      ccsd_space_t space;
      logic        lo;
      logic        hi;
      logic        wr;
      logic        attr;
      logic [1:0]  idx;
   } ccsd_dec_t;

   // space decode from active-high strobes
   function automatic ccsd_dec_t ccsd_decode(input logic ce1, input logic ce2,
                                             input logic attr, input logic rd,
                                             input logic wr, input logic [ADDR_W-1:0] a);
      ccsd_dec_t d;
      d       = '0;
      d.space = SP_NONE;
      d.wr    = wr;
      d.attr  = attr;
      if ((ce1 || ce2) && (rd ^ wr)) begin
         if (!attr) begin
            if (ce1 && ce2 && a[0]) begin
               d.space = SP_INVALID;   // word on odd address
            end else begin
               d.space = SP_COMMON;
               d.lo    = ce1;
               d.hi    = ce2;
            end
         end else if (!ce1 || a[0]) begin
            d.space = SP_INVALID;      // odd or high-lane-only attribute
         end else if (!a[10] && !a[9]) begin
            d.space = wr ? SP_INVALID : SP_INFO;
            d.lo    = !wr;
         end else if (!a[10] && a[9] && (a[8:4] == 5'h00) && !a[3]) begin
            d.space = SP_CFG;
            d.lo    = 1'b1;
            d.idx   = a[2:1];
         end else begin
            d.space = SP_INVALID;      // reserved attribute location
         end
      end
      return d;
   endfunction : ccsd_decode
endpackage : ccsd_pkg

module ccsd_mem #(
   parameter int DW = 16,
   parameter int AW = 10
) (
   // clock
   input  wire logic              mclk,
   // write port, one enable per byte lane
   input  wire logic [DW/8-1:0]   wr_en,
   input  wire logic [AW-1:0]     wr_addr,
   input  wire logic [DW-1:0]     wr_data,
   // read port, data registered
   input  wire logic [AW-1:0]     rd_addr,
   output logic      [DW-1:0]     rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on the array, contents are undefined until written
   always_ff @(posedge mclk) begin
      for (int i = 0; i < DW/8; i++) begin
         if (wr_en[i]) begin
            mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
         end
      end
      rd_data <= mem[rd_addr];
   end
endmodule : ccsd_mem

/* File: ccsd_top.sv */
// card space decoder: common memory, card info area and configuration registers
`timescale 1ns/1ps
module ccsd_top
   import ccsd_pkg::*;
(
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       arst_n,
   // card bus pins
   input  wire logic                       card_ce1_n,
   input  wire logic                       card_ce2_n,
   input  wire logic                       card_reg_n,
   input  wire logic                       card_oe_n,
   input  wire logic                       card_we_n,
   input  wire logic [ccsd_pkg::ADDR_W-1:0] card_addr,
   input  wire logic [ccsd_pkg::DATA_W-1:0] card_data_i,
   output logic      [ccsd_pkg::DATA_W-1:0] card_data_o,
   output logic                            card_data_lo_oe,
   output logic                            card_data_hi_oe,
   // internal card status
   input  wire logic                       card_ready,
   input  wire logic                       card_irq,
   // info area load port
   input  wire logic                       info_wr_en,
   input  wire logic [ccsd_pkg::INFO_AW-1:0] info_wr_addr,
   input  wire logic [7:0]                 info_wr_data,
   // configuration outputs
   output logic [5:0]                      cfg_index,
   output logic                            level_irq,
   output logic                            soft_reset,
   output logic                            power_down_req
);
   import ccsd_pkg::*;

   localparam int PIN_W = 5 + ADDR_W + DATA_W;

   logic [PIN_W-1:0]         sync1_reg;
   logic [PIN_W-1:0]         sync2_reg;
   logic                     s_ce1, s_ce2, s_attr, s_rd, s_we;
   logic [ADDR_W-1:0]        s_addr;
   logic [DATA_W-1:0]        s_data;
   ccsd_dec_t                dec;
   // write capture and read pipeline
   ccsd_dec_t                wq_reg, wq_next;
   logic [ADDR_W-1:0]        wa_reg, wa_next;
   logic [DATA_W-1:0]        wd_reg, wd_next;
   ccsd_dec_t                rq_reg, rq_next;
   logic                     ra0_reg, ra0_next;
   // configuration registers
   logic [7:0]               mode_select_reg, mode_select_next;
   logic [7:0]               card_condition_reg, card_condition_next;
   logic [7:0]               pin_substitute_reg, pin_substitute_next;
   logic [7:0]               socket_copy_reg, socket_copy_next;
   logic                     rdy_prev_reg, rdy_prev_next;
   // output pins
   logic [DATA_W-1:0]        dout_reg, dout_next;
   logic                     lo_oe_reg, lo_oe_next;
   logic                     hi_oe_reg, hi_oe_next;
   // memories
   logic                     commit;
   logic [1:0]               cm_we;
   logic [DATA_W-1:0]        cm_wdata;
   logic [DATA_W-1:0]        cm_rdata;
   logic [7:0]               info_rdata;
   logic [7:0]               cond_rd, pin_rd;

   // two-stage synchroniser on every card pin, only stage two is decoded
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= {5'h1f, {(ADDR_W+DATA_W){1'b0}}};
         sync2_reg <= {5'h1f, {(ADDR_W+DATA_W){1'b0}}};
      end else begin
         sync1_reg <= {card_ce1_n, card_ce2_n, card_reg_n, card_oe_n, card_we_n,
                       card_addr, card_data_i};
         sync2_reg <= sync1_reg;
      end
   end

   assign s_ce1  = !sync2_reg[PIN_W-1];
   assign s_ce2  = !sync2_reg[PIN_W-2];
   assign s_attr = !sync2_reg[PIN_W-3];
   assign s_rd   = !sync2_reg[PIN_W-4];
   assign s_we   = !sync2_reg[PIN_W-5];
   assign s_addr = sync2_reg[DATA_W +: ADDR_W];
   assign s_data = sync2_reg[DATA_W-1:0];

   // standby falls out of the decode when neither enable is low
   assign dec = ccsd_decode(s_ce1, s_ce2, s_attr, s_rd, s_we, s_addr);

   // a write takes effect when the strobe ends, with the last sampled data
   assign commit = wq_reg.wr && (wq_reg.space != SP_NONE) && !s_we;

   // common memory lane enables and data steering
   always_comb begin
      cm_we    = 2'b00;
      cm_wdata = wd_reg;
      if (commit && (wq_reg.space == SP_COMMON)) begin
         if (wq_reg.lo && wq_reg.hi) begin
            cm_we = 2'b11;
         end else if (wq_reg.lo) begin
            cm_we    = wa_reg[0] ? 2'b10 : 2'b01;
            cm_wdata = {wd_reg[7:0], wd_reg[7:0]};
         end else begin
            cm_we    = 2'b10;
         end
      end
   end

   ccsd_mem #(.DW(DATA_W), .AW(CM_AW)) u_common (
      .mclk    (mclk),
      .wr_en   (cm_we),
      .wr_addr (wa_reg[CM_AW:1]),
      .wr_data (cm_wdata),
      .rd_addr (s_addr[CM_AW:1]),
      .rd_data (cm_rdata)
   );

   // host has no write path here, so the info area is only loaded locally
   ccsd_mem #(.DW(8), .AW(INFO_AW)) u_info (
      .mclk    (mclk),
      .wr_en   (info_wr_en),
      .wr_addr (info_wr_addr),
      .wr_data (info_wr_data),
      .rd_addr (s_addr[INFO_AW:1]),
      .rd_data (info_rdata)
   );

   // read views of the status registers, live bits composed here
   assign cond_rd = {pin_substitute_reg[PIN_CRDY] | pin_substitute_reg[PIN_CWPROT],
                     card_condition_reg[6:2], card_irq, 1'b0};
   assign pin_rd  = {2'b00, pin_substitute_reg[PIN_CRDY], pin_substitute_reg[PIN_CWPROT],
                     2'b00, card_ready, 1'b0};

   // next state: capture, registers, read pipeline, pins
   always_comb begin
      wq_next             = dec;
      wa_next             = s_addr;
      wd_next             = s_data;
      rq_next             = dec;
      ra0_next            = s_addr[0];
      mode_select_next    = mode_select_reg;
      card_condition_next = card_condition_reg;
      pin_substitute_next = pin_substitute_reg;
      socket_copy_next    = socket_copy_reg;
      rdy_prev_next       = card_ready;
      dout_next           = dout_reg;
      lo_oe_next          = 1'b0;
      hi_oe_next          = 1'b0;
      // configuration writes, attribute data only on the low lane
      if (commit && (wq_reg.space == SP_CFG)) begin
         unique case (wq_reg.idx)
            CFG_IDX_MODE: mode_select_next = wd_reg[7:0];
            CFG_IDX_COND: card_condition_next =
                             wd_reg[7:0] & COND_WR_MASK;
            CFG_IDX_PIN: begin
               if (wd_reg[PIN_MRDY]) begin
                  pin_substitute_next[PIN_CRDY] = wd_reg[PIN_CRDY];
               end
               if (wd_reg[PIN_MWPROT]) begin
                  pin_substitute_next[PIN_CWPROT] = wd_reg[PIN_CWPROT];
               end
            end
            CFG_IDX_SOCK: socket_copy_next = wd_reg[7:0];
         endcase
      end
      // ready change sets the flag after the host write so set wins
      if (card_ready != rdy_prev_reg) begin
         pin_substitute_next[PIN_CRDY] = 1'b1;
      end
      // read data two cycles after decode; invalid and idle leave lanes off
      unique case (rq_reg.space)
         SP_NONE: begin
         end
         SP_INVALID: begin
         end
         SP_COMMON: begin
            if (!rq_reg.wr) begin
               lo_oe_next = rq_reg.lo;
               hi_oe_next = rq_reg.hi;
               dout_next  = cm_rdata;
               if (rq_reg.lo && !rq_reg.hi && ra0_reg) begin
                  dout_next = {cm_rdata[15:8], cm_rdata[15:8]};
               end
            end
         end
         SP_INFO: begin
            lo_oe_next = 1'b1;
            dout_next  = {8'h00, info_rdata};
         end
         SP_CFG: begin
            if (!rq_reg.wr) begin
               lo_oe_next = 1'b1;
               unique case (rq_reg.idx)
                  CFG_IDX_MODE: dout_next = {8'h00, mode_select_reg};
                  CFG_IDX_COND: dout_next = {8'h00, cond_rd};
                  CFG_IDX_PIN:  dout_next = {8'h00, pin_rd};
                  CFG_IDX_SOCK: dout_next = {8'h00, socket_copy_reg};
               endcase
            end
         end
      endcase
   end

   // register stage for all of the above
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wq_reg             <= '0;
         wa_reg             <= '0;
         wd_reg             <= '0;
         rq_reg             <= '0;
         ra0_reg            <= 1'b0;
         mode_select_reg    <= MODE_RST;
         card_condition_reg <= COND_RST;
         pin_substitute_reg <= PIN_RST;
         socket_copy_reg    <= SOCK_RST;
         rdy_prev_reg       <= 1'b0;
         dout_reg           <= '0;
         lo_oe_reg          <= 1'b0;
         hi_oe_reg          <= 1'b0;
      end else begin
         wq_reg             <= wq_next;
         wa_reg             <= wa_next;
         wd_reg             <= wd_next;
         rq_reg             <= rq_next;
         ra0_reg            <= ra0_next;
         mode_select_reg    <= mode_select_next;
         card_condition_reg <= card_condition_next;
         pin_substitute_reg <= pin_substitute_next;
         socket_copy_reg    <= socket_copy_next;
         rdy_prev_reg       <= rdy_prev_next;
         dout_reg           <= dout_next;
         lo_oe_reg          <= lo_oe_next;
         hi_oe_reg          <= hi_oe_next;
      end
   end

   // outputs straight from flops
   assign card_data_o     = dout_reg;
   assign card_data_lo_oe = lo_oe_reg;
   assign card_data_hi_oe = hi_oe_reg;
   assign cfg_index       = mode_select_reg[5:0];
   assign level_irq       = mode_select_reg[MODE_LEVIREQ];
   assign soft_reset      = mode_select_reg[MODE_SRESET];
   assign power_down_req  = card_condition_reg[COND_PWRDWN];

   // checks on the decoded pins and the lane drivers
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_common_rd;
      dec.space == SP_COMMON && !dec.wr;
   endsequence

   sequence s_cfg_wr_end(logic [1:0] i);
      wq_reg.space == SP_CFG && wq_reg.wr && wq_reg.idx == i && !s_we;
   endsequence

   property p_lo_read;
      s_common_rd and (dec.lo && !dec.hi) |-> ##2 (lo_oe_reg && !hi_oe_reg);
   endproperty
   a_lo_read: assert property (p_lo_read) else $error("low lane read not driven");

   property p_hi_read;
      s_common_rd and (!dec.lo && dec.hi) |-> ##2 (hi_oe_reg && !lo_oe_reg);
   endproperty
   a_hi_read: assert property (p_hi_read) else $error("high lane read not driven");

   property p_word_read;
      s_common_rd and (dec.lo && dec.hi) |-> ##2 (lo_oe_reg && hi_oe_reg);
   endproperty
   a_word_read: assert property (p_word_read) else $error("word read not driven");

   property p_word_write;
      (dec.space == SP_COMMON && dec.wr && dec.lo && dec.hi) ##1 !s_we
         |-> cm_we == 2'b11;
   endproperty
   a_word_write: assert property (p_word_write) else $error("word write lanes wrong");

   property p_info_read;
      dec.space == SP_INFO |-> ##2 (lo_oe_reg && dout_reg[7:0] == $past(info_rdata));
   endproperty
   a_info_read: assert property (p_info_read) else $error("info area read wrong");

   property p_bad_write;
      commit && wq_reg.space == SP_INVALID |=>
         $stable(mode_select_reg) && $stable(socket_copy_reg) && $stable(card_condition_reg);
   endproperty
   a_bad_write: assert property (p_bad_write) else $error("invalid write changed state");

   property p_info_wr_dec;
      s_attr && s_we && !s_rd && s_ce1 && !s_addr[0] && !s_addr[10] && !s_addr[9]
         |-> dec.space == SP_INVALID;
   endproperty
   a_info_wr_dec: assert property (p_info_wr_dec) else $error("info area write accepted");

   property p_bad_read;
      dec.space == SP_INVALID && !dec.wr |-> ##2 (!lo_oe_reg && !hi_oe_reg);
   endproperty
   a_bad_read: assert property (p_bad_read) else $error("invalid read drove data");

   property p_mode_wr;
      s_cfg_wr_end(CFG_IDX_MODE) |=> mode_select_reg == $past(wd_reg[7:0]);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode select write lost");

   property p_sock_wr;
      s_cfg_wr_end(CFG_IDX_SOCK) |=> socket_copy_reg == $past(wd_reg[7:0]);
   endproperty
   a_sock_wr: assert property (p_sock_wr) else $error("socket copy write lost");

   property p_attr_lane;
      s_attr && s_rd && !s_we && (s_ce1 || s_ce2) |-> ##2 !hi_oe_reg;
   endproperty
   a_attr_lane: assert property (p_attr_lane) else $error("attribute data on high lane");

   property p_standby;
      !s_ce1 && !s_ce2 |-> ##2 (!lo_oe_reg && !hi_oe_reg) ##0 !commit[*1];
   endproperty
   a_standby: assert property (p_standby) else $error("lanes driven in standby");
endmodule : ccsd_top

/* File: ccsd_host.sv */
// host socket controller model that drives the card bus strobes
`timescale 1ns/1ps
module ccsd_host (
   // clock
   input  wire logic                        mclk,
   // enables, strobes and address toward the card
   output logic                             card_ce1_n,
   output logic                             card_ce2_n,
   output logic                             card_reg_n,
   output logic                             card_oe_n,
   output logic                             card_we_n,
   output logic      [ccsd_pkg::ADDR_W-1:0] card_addr,
   // data lanes
   output logic      [ccsd_pkg::DATA_W-1:0] card_data_i,
   input  wire logic [ccsd_pkg::DATA_W-1:0] card_data_o,
   input  wire logic                        card_data_lo_oe,
   input  wire logic                        card_data_hi_oe
);
   import ccsd_pkg::*;

   // bus parked in standby until the first cycle
   initial begin
      card_ce1_n  = 1'b1;
      card_ce2_n  = 1'b1;
      card_reg_n  = 1'b1;
      card_oe_n   = 1'b1;
      card_we_n   = 1'b1;
      card_addr   = '0;
      card_data_i = 16'hC35A;
   end

   // one bus cycle; f holds write, attribute, low lane, high lane
   task automatic access(input logic [3:0] f, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] wd, input int len,
                         output logic [DATA_W-1:0] rd, output logic [1:0] oe);
      @(negedge mclk);
      card_ce1_n  = !f[1];
      card_ce2_n  = !f[0];
      card_reg_n  = !f[2];   // attribute targets come from the caller
      card_addr   = a;
      card_data_i = f[3] ? wd : ~card_data_i;
      card_oe_n   = f[3];
      card_we_n   = !f[3];
      // strobe held long enough for the synchronised edge to be seen
      repeat (len) @(negedge mclk);
      rd          = card_data_o;
      oe          = {card_data_hi_oe, card_data_lo_oe};
      card_oe_n   = 1'b1;
      card_we_n   = 1'b1;
      // address and data held past the rising strobe so the commit sees them
      repeat (4) @(negedge mclk);
      card_ce1_n  = 1'b1;
      card_ce2_n  = 1'b1;
      card_reg_n  = 1'b1;
      card_data_i = ~card_data_i;   // released lanes do not keep the old value
      repeat (4) @(negedge mclk);
   endtask : access
endmodule : ccsd_host

/* File: testbench.sv */
// self-checking bench for the card space decoder
`timescale 1ns/1ps
module testbench;
   import ccsd_pkg::*;
   typedef struct packed {
      logic [3:0]        f;   // write, attribute, low lane, high lane
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic [1:0]        e;   // expected high and low lane enables
      logic [DATA_W-1:0] x;   // expected data on the enabled lanes
   } ccsd_row_t;
   logic                mclk, arst_n, ce1_n, ce2_n, reg_n, oe_n, we_n;
   logic                lo_oe, hi_oe, card_ready, card_irq, info_wr_en;
   logic                level_irq, soft_reset, power_down_req;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   data_i, data_o;
   logic [7:0]          info_wr_addr, info_wr_data;
   logic [5:0]          cfg_index;
   int                  err_total, checked;

   // ordinary cases: reset values, lanes, registers, refusals, standby
   localparam ccsd_row_t ROWS [0:38] = '{
      '{4'h6, 11'h200, '0, 2'h1, '0}, '{4'h6, 11'h202, '0, 2'h1, '0},
      '{4'h6, 11'h204, '0, 2'h1, '0}, '{4'h6, 11'h206, '0, 2'h1, '0},
      '{4'hB, 11'h010, 16'hA55A, '0, '0}, '{4'h3, 11'h010, '0, 2'h3, 16'hA55A},
      '{4'h2, 11'h010, '0, 2'h1, 16'h005A}, '{4'h2, 11'h011, '0, 2'h1, 16'h00A5},
      '{4'h1, 11'h010, '0, 2'h2, 16'hA500}, '{4'hA, 11'h020, 16'h00C3, '0, '0},
      '{4'h9, 11'h020, 16'h3C00, '0, '0}, '{4'hB, 11'h021, 16'h1234, '0, '0},
      '{4'h3, 11'h021, '0, 2'h0, '0}, '{4'h3, 11'h020, '0, 2'h3, 16'h3CC3},
      '{4'hE, 11'h200, 16'h0041, '0, '0}, '{4'h6, 11'h200, '0, 2'h1, 16'h0041},
      '{4'hE, 11'h202, 16'h00FF, '0, '0}, '{4'h6, 11'h202, '0, 2'h1, 16'h0064},
      '{4'hE, 11'h204, 16'h0022, '0, '0}, '{4'h6, 11'h204, '0, 2'h1, 16'h0020},
      '{4'hF, 11'h206, 16'h005A, '0, '0}, '{4'h7, 11'h206, '0, 2'h1, 16'h005A},
      '{4'h6, 11'h201, '0, 2'h0, '0}, '{4'h5, 11'h200, '0, 2'h0, '0},
      '{4'hE, 11'h201, 16'h00FF, '0, '0}, '{4'hD, 11'h200, 16'hFFFF, '0, '0},
      '{4'hE, 11'h280, 16'h00FF, '0, '0}, '{4'hE, 11'h600, 16'h00FF, '0, '0},
      '{4'h6, 11'h200, '0, 2'h1, 16'h0041}, '{4'h6, 11'h280, '0, 2'h0, '0},
      '{4'h6, 11'h004, '0, 2'h1, 16'h00B7}, '{4'h7, 11'h004, '0, 2'h1, 16'h00B7},
      '{4'hE, 11'h004, 16'h0011, '0, '0}, '{4'h6, 11'h004, '0, 2'h1, 16'h00B7},
      '{4'h6, 11'h005, '0, 2'h0, '0}, '{4'h4, 11'h200, '0, 2'h0, '0},
      '{4'h8, 11'h010, 16'hFFFF, '0, '0}, '{4'h3, 11'h010, '0, 2'h3, 16'hA55A},
      '{4'h6, 11'h600, '0, 2'h0, '0}};

   ccsd_top ccsd_top_inst (.mclk(mclk), .arst_n(arst_n), .card_ce1_n(ce1_n),
      .card_ce2_n(ce2_n), .card_reg_n(reg_n), .card_oe_n(oe_n), .card_we_n(we_n),
      .card_addr(addr), .card_data_i(data_i), .card_data_o(data_o),
      .card_data_lo_oe(lo_oe), .card_data_hi_oe(hi_oe), .card_ready(card_ready),
      .card_irq(card_irq), .info_wr_en(info_wr_en), .info_wr_addr(info_wr_addr),
      .info_wr_data(info_wr_data), .cfg_index(cfg_index), .level_irq(level_irq),
      .soft_reset(soft_reset), .power_down_req(power_down_req));

   ccsd_host ccsd_host_inst (.mclk(mclk), .card_ce1_n(ce1_n), .card_ce2_n(ce2_n),
      .card_reg_n(reg_n), .card_oe_n(oe_n), .card_we_n(we_n), .card_addr(addr),
      .card_data_i(data_i), .card_data_o(data_o), .card_data_lo_oe(lo_oe),
      .card_data_hi_oe(hi_oe));

   // free-running clock, 100 MHz
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // verdict and end of run
   task automatic test_done();
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   // lane enables and data on the enabled lanes only
   task automatic check_read(input logic [1:0] ex_oe, input logic [15:0] ex_d,
                             input logic [1:0] oe, input logic [15:0] d);
      logic [15:0] m;
      m = {{8{ex_oe[1]}}, {8{ex_oe[0]}}};
      checked++;
      if (oe !== ex_oe || (d & m) !== (ex_d & m)) begin
         err_total++;
         $display("wrong value at %0t: read %b %h, expected %b %h", $time, oe, d, ex_oe, ex_d);
      end
   endtask : check_read

   // configuration outputs as one word
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: outputs %h, expected %h", $time, got, exp);
      end
   endtask : check_val

   // one bus cycle, checked when it is a read
   task automatic run(input logic [3:0] f, input logic [10:0] a, input logic [15:0] d,
                      input logic [1:0] e, input logic [15:0] x, input int len);
      logic [15:0] rd;
      logic [1:0]  oe;
      ccsd_host_inst.access(f, a, d, len, rd, oe);
      if (!f[3]) check_read(e, x, oe, rd);
   endtask : run

   // watchdog, a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge mclk);
      err_total++;
      test_done();
   end

   // main sequence
   initial begin
      err_total = 0;
      checked = 0;
      arst_n = 1'b0;
      {card_ready, card_irq, info_wr_en, info_wr_addr, info_wr_data} = '0;
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      info_wr_addr = 8'h02;
      info_wr_data = 8'hB7;
      info_wr_en = 1'b1;
      @(negedge mclk);
      info_wr_en = 1'b0;
      // slow and prompt host cycles alternate through the table
      for (int i = 0; i < 39; i++) begin
         run(ROWS[i].f, ROWS[i].a, ROWS[i].d, ROWS[i].e, ROWS[i].x, 6 + 6 * (i % 2));
      end
      check_val({7'h00, soft_reset, level_irq, cfg_index, power_down_req}, 16'h0083);
      // crdy cleared by host, then set by a ready change while irq stands
      run(4'hE, 11'h204, 16'h0002, '0, '0, 6);
      run(4'h6, 11'h204, '0, 2'h1, 16'h0000, 6);
      card_ready = 1'b1;
      card_irq = 1'b1;
      run(4'h6, 11'h204, '0, 2'h1, 16'h0022, 6);
      run(4'h6, 11'h202, '0, 2'h1, 16'h00E6, 6);
      run(4'hE, 11'h200, 16'h0080, '0, '0, 6);
      check_val({7'h00, soft_reset, level_irq, cfg_index, power_down_req}, 16'h0101);
      // reset in mid-run returns every configuration register to zero
      card_ready = 1'b0;
      repeat (4) @(negedge mclk);
      arst_n = 1'b0;
      repeat (5) @(negedge mclk);
      check_val({7'h00, soft_reset, level_irq, cfg_index, power_down_req}, 16'h0000);
      arst_n = 1'b1;
      run(4'h6, 11'h200, '0, 2'h1, 16'h0000, 6);
      run(4'h6, 11'h202, '0, 2'h1, 16'h0002, 6);
      run(4'h6, 11'h204, '0, 2'h1, 16'h0000, 6);
      run(4'h6, 11'h206, '0, 2'h1, 16'h0000, 6);
      test_done();
   end
endmodule : testbench
